// ### mrp_pkg.sv
// Purpose: Shared constants and types for the memory relocation and paging decoder
// Assumes: Register indices map to AXI4-Lite byte addresses at four times the index
// Notes: Stretch counts are in E clocks
package mrp_pkg;
   // Register indices
   localparam logic [7:0] IDX_RAM_BASE = 8'h10;
   localparam logic [7:0] IDX_EEP_BASE = 8'h12;
   localparam logic [7:0] IDX_MAP_CTRL = 8'h13;
   localparam logic [7:0] IDX_DEC_STAT = 8'h14;
   localparam logic [7:0] IDX_PAGE = 8'h30;
   localparam logic [7:0] IDX_PORT_PULL = 8'hFE;
   localparam logic [7:0] IDX_PORT_DATA = 8'hFC;
   localparam logic [7:0] IDX_PORT_DIR = 8'hFD;
   // Reset values
   localparam logic [7:0] RAM_BASE_RST = 8'h20;
   localparam logic [7:0] EEP_BASE_RST = 8'h01;
   localparam logic [7:0] MAP_CTRL_RST = 8'h0C;
   localparam logic [7:0] PORT_DIR_RST = 8'h00;
   localparam logic [7:0] PORT_DATA_RST = 8'h00;
   localparam logic [7:0] PORT_PULL_RST = 8'h00;
   localparam logic [2:0] PAGE_RST = 3'h0;
   // Field masks and positions
   localparam logic [7:0] RAM_BASE_MASK = 8'hE0;
   localparam logic [7:0] EEP_BASE_MASK = 8'hF0;
   localparam logic [7:0] PORT_BIT_MASK = 8'h8F;
   localparam int EEP_ON_BIT = 0;
   localparam int CTRL_TEST_BIT = 7;
   localparam int CTRL_STR_LSB = 2;
   localparam int CTRL_EMU_BIT = 0;
   // Address map
   localparam logic [15:0] REG_BLOCK_TOP = 16'h03FF;
   localparam logic [15:0] FLASH_REG_LO = 16'h00F4;
   localparam logic [15:0] FLASH_REG_HI = 16'h00F7;
   localparam logic [15:0] BDM_LO = 16'hFF00;
   localparam logic [11:0] RAM_HALF_LAST = 12'hFFF;
   // Pin index of the emulation chip select and the general-only pin
   localparam int PIN_CS = 4;
   localparam int PIN_GPIO = 3;
   localparam int NPINS = 5;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic bdm;
      logic regs;
      logic flash_regs;
      logic ram;
      logic eeprom;
      logic flash;
      logic external;
      logic window;
      logic [1:0] array;
      logic [14:0] offset;
   } mrp_sel_t;

   typedef struct packed {
      logic [15:0] addr;
      logic word;
      logic valid;
   } mrp_cpu_t;
endpackage : mrp_pkg

// ### mrp_decoder.sv
// Purpose: Combinational address decode for RAM, EEPROM, flash windows and register space
// Assumes: Register block fixed at address zero
// Notes: One resource selected per address by precedence
`timescale 1ns/10ps
module mrp_decoder
(
   // Access
   input wire logic [15:0] addr,
   input wire logic word,
   // Mapping state
   input wire logic bdm_active,
   input wire logic expanded,
   input wire logic [7:0] ram_base,
   input wire logic [7:0] eep_base,
   input wire logic [2:0] page,
   input wire logic test_win,
   // Result
   output mrp_pkg::mrp_sel_t sel,
   output logic split
);
   import mrp_pkg::*;

   logic hit_bdm, hit_reg, hit_ram, hit_eep, hit_win, hit_fix;

   always_comb
   begin
      hit_bdm = bdm_active && (addr >= BDM_LO);
      hit_reg = (addr <= REG_BLOCK_TOP);
      hit_ram = (addr[15:13] == ram_base[7:5]);
      hit_eep = eep_base[EEP_ON_BIT] && (addr[15:12] == eep_base[7:4]) && addr[11];
      hit_win = test_win ? addr[15] : (addr[15:14] == 2'b10);
      hit_fix = !test_win && ((addr[15:14] == 2'b01) || (addr[15:14] == 2'b11));
      sel = '0;
      if (hit_bdm)
         sel.bdm = 1'b1;
      else if (hit_reg)
      begin
         sel.regs = 1'b1;
         // array from index bits 2 and 1
         sel.flash_regs = (addr >= FLASH_REG_LO) && (addr <= FLASH_REG_HI);
         sel.array = page[2:1];
      end
      else if (hit_ram)
         sel.ram = 1'b1;
      else if (hit_eep)
         sel.eeprom = 1'b1;
      else if (hit_win)
      begin
         sel.flash = 1'b1;
         sel.window = 1'b1;
         sel.array = page[2:1];
         sel.offset = test_win ? addr[14:0] : {page[0], addr[13:0]};
      end
      else if (hit_fix)
      begin
         // fixed views of pages 6 and 7
         sel.flash = 1'b1;
         sel.array = 2'b11;
         sel.offset = {addr[15], addr[13:0]};
      end
      else
         sel.external = expanded;
      split = word && sel.ram && !addr[12] && (addr[11:0] == RAM_HALF_LAST);
   end
endmodule : mrp_decoder

// ### mrp_top.sv
// Purpose: Mapping registers, emulation port and AXI4-Lite slave around the address decoder
// Assumes: Core access and E clock phase come from logic on core_clk
// Notes: Mode straps and port pins are synchronised before use
`timescale 1ns/10ps
module mrp_top
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core bus
   input mrp_pkg::mrp_cpu_t cpu,
   input wire logic e_high,
   input wire logic bdm_active,
   output mrp_pkg::mrp_sel_t cpu_sel,
   output logic cpu_split,
   // Mode straps
   input wire logic mode_special_pin,
   input wire logic mode_expanded_pin,
   input wire logic mode_peripheral_pin,
   // Emulation port pins: 0..2 index, 3 general, 4 chip select
   input wire logic [4:0] port_pin_in,
   output logic [4:0] port_pin_out,
   output logic [4:0] port_pin_oe,
   output logic [4:0] port_pin_pullup
);
   import mrp_pkg::*;

   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic [7:0] sync1_reg, sync2_reg;
   logic special, expanded, periph;
   logic [4:0] pin_level;
   logic [7:0] ram_base_reg, eep_base_reg, map_ctrl_reg;
   logic [7:0] ram_eff_reg, eep_eff_reg, ctrl_eff_reg;
   logic [7:0] port_data_reg, port_dir_reg, port_pull_reg;
   logic [2:0] page_reg;
   logic ram_locked_reg, eep_locked_reg, ctrl_locked_reg;
   logic bvalid_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] stat_reg;
   logic wr_fire, rd_fire, port_hidden, wr_ok, rd_ok;
   logic [7:0] wr_idx, rd_idx, wdata;
   logic emu_on, test_win;
   logic ecs_n_reg, e_high_d_reg;
   logic [1:0] stretch_reg;
   logic ecs_hit;
   mrp_sel_t sel;
   logic [4:0] pin_drv, pin_dir, pin_data, pin_pull;

   // Returns whether a register index answers on the bus
   function automatic logic reg_mapped(input logic [7:0] idx, input logic hide);
      case (idx)
         IDX_RAM_BASE, IDX_EEP_BASE, IDX_MAP_CTRL, IDX_DEC_STAT, IDX_PAGE: reg_mapped = 1'b1;
         IDX_PORT_DATA, IDX_PORT_DIR, IDX_PORT_PULL: reg_mapped = !hide;
         default: reg_mapped = 1'b0;
      endcase
   endfunction : reg_mapped

   // Pin bits in port register order 0,1,2,3,7
   function automatic logic [4:0] to_pins(input logic [7:0] v);
      to_pins = {v[7], v[3:0]};
   endfunction : to_pins

   // Reset release
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // Strap and pin synchronisers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end
      else
      begin
         sync1_reg <= {mode_peripheral_pin, mode_expanded_pin, mode_special_pin, port_pin_in};
         sync2_reg <= sync1_reg;
      end
   end
   assign pin_level = sync2_reg[4:0];
   assign special = sync2_reg[5];
   assign expanded = sync2_reg[6];
   assign periph = sync2_reg[7];

   assign emu_on = ctrl_eff_reg[CTRL_EMU_BIT];
   assign test_win = ctrl_eff_reg[CTRL_TEST_BIT] && special;
   assign port_hidden = emu_on && (expanded || periph);

   // Bus decode
   assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
   assign rd_fire = s_axi_arvalid && !rvalid_reg;
   assign wr_idx = s_axi_awaddr[9:2];
   assign rd_idx = s_axi_araddr[9:2];
   assign wdata = s_axi_wdata[7:0];
   assign wr_ok = reg_mapped(wr_idx, port_hidden) && (s_axi_awaddr[31:10] == 22'h0);
   assign rd_ok = reg_mapped(rd_idx, port_hidden) && (s_axi_araddr[31:10] == 22'h0);
   assign s_axi_awready = wr_fire;
   assign s_axi_wready = wr_fire;
   assign s_axi_arready = rd_fire;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   // Write response
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // Mapping registers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ram_base_reg <= RAM_BASE_RST;
         eep_base_reg <= EEP_BASE_RST;
         map_ctrl_reg <= MAP_CTRL_RST;
         ram_locked_reg <= 1'b0;
         eep_locked_reg <= 1'b0;
         ctrl_locked_reg <= 1'b0;
      end
      else if (wr_fire && wr_ok && s_axi_wstrb[0])
      begin
         if (wr_idx == IDX_RAM_BASE && (!ram_locked_reg || special))
         begin
            ram_base_reg <= wdata & RAM_BASE_MASK;
            ram_locked_reg <= 1'b1;
         end
         if (wr_idx == IDX_EEP_BASE)
         begin
            eep_base_reg[EEP_ON_BIT] <= wdata[EEP_ON_BIT];
            if (!eep_locked_reg || special)
            begin
               eep_base_reg[7:4] <= wdata[7:4];
               eep_locked_reg <= 1'b1;
            end
         end
         if (wr_idx == IDX_MAP_CTRL && (!ctrl_locked_reg || special))
         begin
            map_ctrl_reg <= wdata & 8'h8D;
            ctrl_locked_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ram_eff_reg <= RAM_BASE_RST;
         eep_eff_reg <= EEP_BASE_RST;
         ctrl_eff_reg <= MAP_CTRL_RST;
      end
      else
      begin
         ram_eff_reg <= ram_base_reg;
         eep_eff_reg <= eep_base_reg;
         ctrl_eff_reg <= map_ctrl_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         page_reg <= PAGE_RST;
      else if (wr_fire && wr_ok && s_axi_wstrb[0] && wr_idx == IDX_PAGE)
         page_reg <= wdata[2:0];
   end

   // Port registers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port_data_reg <= PORT_DATA_RST;
         port_dir_reg <= PORT_DIR_RST;
         port_pull_reg <= PORT_PULL_RST;
      end
      else if (wr_fire && wr_ok && s_axi_wstrb[0])
      begin
         if (wr_idx == IDX_PORT_DATA)
            port_data_reg <= wdata & PORT_BIT_MASK;
         if (wr_idx == IDX_PORT_DIR)
            port_dir_reg <= wdata & PORT_BIT_MASK;
         if (wr_idx == IDX_PORT_PULL)
            port_pull_reg <= wdata & PORT_BIT_MASK;
      end
   end

   // Read data
   always_comb
   begin
      rdata_next = 32'h0;
      case (rd_idx)
         IDX_RAM_BASE: rdata_next[7:0] = ram_base_reg;
         IDX_EEP_BASE: rdata_next[7:0] = eep_base_reg;
         IDX_MAP_CTRL: rdata_next[7:0] = map_ctrl_reg;
         IDX_DEC_STAT: rdata_next[7:0] = stat_reg;
         IDX_PAGE: rdata_next[2:0] = page_reg;
         IDX_PORT_DATA: rdata_next[7:0] = {pin_level[4], 3'h0, pin_level[3:0]};
         IDX_PORT_DIR: rdata_next[7:0] = port_dir_reg;
         IDX_PORT_PULL: rdata_next[7:0] = port_pull_reg;
         default: rdata_next = 32'h0;
      endcase
      if (!rd_ok)
         rdata_next = 32'h0;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0;
      end
      else if (rd_fire)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         rdata_reg <= rdata_next;
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   mrp_decoder u_decoder
   (
      .addr(cpu.addr),
      .word(cpu.word),
      .bdm_active(bdm_active),
      .expanded(expanded),
      .ram_base(ram_eff_reg),
      .eep_base(eep_eff_reg),
      .page(page_reg),
      .test_win(test_win),
      .sel(sel),
      .split(cpu_split)
   );
   assign cpu_sel = sel;

   // Last decoded resource, for software
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         stat_reg <= 8'h00;
      else if (cpu.valid)
         stat_reg <= {sel.bdm, sel.regs, sel.flash_regs, sel.ram, sel.eeprom, sel.flash, sel.external, sel.window};
   end

   // window hit to flash or external
   assign ecs_hit = cpu.valid && emu_on && sel.window && (sel.flash || sel.external);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ecs_n_reg <= 1'b1;
         e_high_d_reg <= 1'b0;
         stretch_reg <= 2'h0;
      end
      else
      begin
         e_high_d_reg <= e_high;
         if (e_high_d_reg && !e_high)
         begin
            if (stretch_reg != 2'h0)
               stretch_reg <= stretch_reg - 2'h1;
            else if (ecs_hit && sel.external)
               stretch_reg <= ctrl_eff_reg[CTRL_STR_LSB +: 2];
         end
         if (!emu_on)
            ecs_n_reg <= 1'b1;
         else
            ecs_n_reg <= !((ecs_hit && e_high) || stretch_reg != 2'h0);
      end
   end

   // Emulation outputs per pin
   assign pin_drv = {ecs_n_reg, 1'b0, page_reg};
   assign pin_dir = to_pins(port_dir_reg);
   assign pin_data = to_pins(port_data_reg);
   assign pin_pull = to_pins(port_pull_reg);
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++)
      begin : g_pin
         logic emu_pin;
         assign emu_pin = emu_on && (gi != PIN_GPIO);
         assign port_pin_out[gi] = emu_pin ? pin_drv[gi] : pin_data[gi];
         assign port_pin_oe[gi] = emu_pin || pin_dir[gi];
         assign port_pin_pullup[gi] = !port_pin_oe[gi] && pin_pull[gi];
      end
   endgenerate

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_locked_ram_write;
      !special && ram_locked_reg && wr_fire && wr_ok && s_axi_wstrb[0] && wr_idx == IDX_RAM_BASE;
   endsequence

   a_ram_write_once: assert property (s_locked_ram_write |=> $stable(ram_base_reg))
      else $error("RAM position changed after lock");
   a_map_eff_delay: assert property ($changed(ram_base_reg) |=> ram_eff_reg == $past(ram_base_reg))
      else $error("RAM position not applied one cycle later");
   a_eep_disabled: assert property (!eep_eff_reg[EEP_ON_BIT] |-> !sel.eeprom)
      else $error("EEPROM decoded while disabled");
   a_user_window: assert property (sel.window && !test_win |-> sel.array == page_reg[2:1]
      && sel.offset[14] == page_reg[0] && cpu.addr[15:14] == 2'b10)
      else $error("Program window page mismatch");
   a_fixed_page6: assert property (sel.flash && !test_win && cpu.addr[15:14] == 2'b01
      |-> sel.array == 2'b11 && !sel.offset[14])
      else $error("Fixed page 6 mapping wrong");
   a_pix_pins: assert property (emu_on |-> port_pin_out[2:0] == page_reg && port_pin_oe[2:0] == 3'h7)
      else $error("Index pins do not follow page index");
   a_ecs_idle: assert property (!emu_on |=> ecs_n_reg)
      else $error("Chip select active without emulation");
   a_dir_input: assert property (!emu_on && !port_dir_reg[0] |-> !port_pin_oe[0])
      else $error("Input pin driven");
   a_ram_split: assert property (cpu.word && sel.ram && cpu.addr[12:0] == 13'h0FFF |-> cpu_split)
      else $error("Straddling word not split");
   a_port_hidden: assert property (rd_fire && port_hidden && rd_idx == IDX_PORT_DIR
      |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
      else $error("Hidden port register answered");
endmodule : mrp_top

// ### mrp_core_model.sv
// Purpose: Core bus model presenting accesses and the E clock phase
// Assumes: Bench requests change just after a rising edge
// Notes: A released address shows the inverse of the last one
`timescale 1ns/10ps
module mrp_core_model
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Requests from the bench
   input wire logic [15:0] req_addr,
   input wire logic req_word,
   input wire logic req_valid,
   // Core bus
   output mrp_pkg::mrp_cpu_t cpu,
   output logic e_high
);
   import mrp_pkg::*;
   // one access per cycle, applied an edge later
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cpu <= '0;
         e_high <= 1'b0;
      end
      else
      begin
         e_high <= ~e_high;
         cpu.valid <= req_valid;
         cpu.word <= req_word;
         cpu.addr <= req_valid ? req_addr : ~cpu.addr;
      end
   end
endmodule : mrp_core_model

// ### memory_relocation_paging_decoder_bench.sv
// Purpose: Self-checking bench for the mapping decoder
// Assumes: Core model drives accesses, bench drives AXI4-Lite
// Notes: A second reset runs special expanded mode
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module memory_relocation_paging_decoder_bench;
   import mrp_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic [3:0] wstrb = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [15:0] req_addr = '0;
   logic req_word = 1'b0, req_valid = 1'b0, e_high, cpu_split, m_sp = 1'b0, m_ex = 1'b0, bdm = 1'b0;
   mrp_cpu_t cpu;
   mrp_sel_t cpu_sel;
   logic [4:0] pin_in, pin_out, pin_oe, pin_pu, pin_float = '0;
   int n_mismatch = 0, compares = 0, cycles = 0;
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) pin_float <= ~pin_float;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pu | pin_float));
   mrp_core_model i_core (.core_clk(core_clk), .arst_n(arst_n), .req_addr(req_addr), .req_word(req_word),
      .req_valid(req_valid), .cpu(cpu), .e_high(e_high));
   mrp_top i_dut (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu(cpu), .e_high(e_high),
      .bdm_active(bdm), .cpu_sel(cpu_sel), .cpu_split(cpu_split), .mode_special_pin(m_sp),
      .mode_expanded_pin(m_ex), .mode_peripheral_pin(1'b0), .port_pin_in(pin_in), .port_pin_out(pin_out),
      .port_pin_oe(pin_oe), .port_pin_pullup(pin_pu));
   task automatic close_out;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge core_clk);
      awaddr <= {22'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(negedge core_clk); while (!(awready === 1'b1 && wready === 1'b1));
      @(posedge core_clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(negedge core_clk); while (bvalid !== 1'b1);
      `CHK("bresp", er, bresp)
      @(posedge core_clk);
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
      @(posedge core_clk);
      araddr <= {22'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge core_clk); while (arready !== 1'b1);
      @(posedge core_clk);
      arvalid <= 1'b0;
      do @(negedge core_clk); while (rvalid !== 1'b1);
      `CHK("rresp", er, rresp)
      `CHK("rdata", {24'h0, ed}, rdata)
      @(posedge core_clk);
      rready <= 1'b0;
   endtask : axi_rd
   task automatic look(input logic [15:0] a, input logic w);
      @(posedge core_clk);
      req_addr <= a;
      req_word <= w;
      req_valid <= 1'b1;
      @(posedge core_clk);
      @(negedge core_clk);
   endtask : look
   task automatic cs_seen(output logic h);
      h = 1'b0;
      repeat (6)
      begin
         @(negedge core_clk);
         if (pin_out[PIN_CS] === 1'b0)
            h = 1'b1;
      end
   endtask : cs_seen
   task automatic do_reset(input logic sp, input logic ex);
      @(posedge core_clk);
      arst_n <= 1'b0;
      m_sp <= sp;
      m_ex <= ex;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask : do_reset
   task automatic t_reset;
      @(negedge core_clk);
      `CHK("oe_rst", 5'h00, pin_oe)
      axi_rd(IDX_RAM_BASE, 8'h20, RESP_OKAY);
      axi_rd(IDX_EEP_BASE, 8'h01, RESP_OKAY);
      axi_rd(IDX_PAGE, 8'h00, RESP_OKAY);
      axi_rd(IDX_PORT_DIR, 8'h00, RESP_OKAY);
      axi_rd(8'h40, 8'h00, RESP_SLVERR);
      axi_wr(8'h41, 8'h55, RESP_SLVERR);
   endtask : t_reset
   task automatic t_ram;
      look(16'h2000, 1'b0);
      `CHK("ram", 1'b1, cpu_sel.ram)
      look(16'h1FFF, 1'b0);
      `CHK("ram_lo", 1'b0, cpu_sel.ram)
      look(16'h2FFF, 1'b1);
      `CHK("split", 1'b1, cpu_split)
      look(16'h2FFE, 1'b1);
      `CHK("nosplit", 1'b0, cpu_split)
      axi_wr(IDX_RAM_BASE, 8'h40, RESP_OKAY);
      axi_wr(IDX_RAM_BASE, 8'h60, RESP_OKAY);
      axi_rd(IDX_RAM_BASE, 8'h40, RESP_OKAY);
      repeat (2) @(posedge core_clk);
      look(16'h4000, 1'b0);
      `CHK("ram_fl", 2'h2, {cpu_sel.ram, cpu_sel.flash})
   endtask : t_ram
   task automatic t_eeprom;
      look(16'h0FFF, 1'b0);
      `CHK("ee", 1'b1, cpu_sel.eeprom)
      look(16'h0500, 1'b0);
      `CHK("ee_lo", 1'b0, cpu_sel.eeprom)
      axi_wr(IDX_EEP_BASE, 8'h00, RESP_OKAY);
      look(16'h0800, 1'b0);
      `CHK("ee_off", 1'b0, cpu_sel.eeprom)
      axi_wr(IDX_EEP_BASE, 8'h31, RESP_OKAY);
      axi_rd(IDX_EEP_BASE, 8'h01, RESP_OKAY);
      look(16'h0800, 1'b0);
      `CHK("ee_on", 1'b1, cpu_sel.eeprom)
   endtask : t_eeprom
   task automatic t_pages;
      for (int p = 0; p < 8; p++)
      begin
         axi_wr(IDX_PAGE, 8'(p), RESP_OKAY);
         axi_rd(IDX_PAGE, 8'(p), RESP_OKAY);
         look(16'h8000, 1'b0);
         `CHK("win", 2'h3, {cpu_sel.window, cpu_sel.flash})
         `CHK("arr", 2'(p >> 1), cpu_sel.array)
         `CHK("half", 15'((p % 2) * 16384), cpu_sel.offset)
         look(16'h00F5, 1'b0);
         `CHK("freg", 3'(4 + (p >> 1)), {cpu_sel.flash_regs, cpu_sel.array})
      end
      look(16'h6000, 1'b0);
      `CHK("fix6", 17'h1A000, {cpu_sel.array, cpu_sel.offset})
      look(16'hC000, 1'b0);
      `CHK("fix7", 18'h1C000, {cpu_sel.window, cpu_sel.array, cpu_sel.offset})
   endtask : t_pages
   task automatic t_emu;
      logic h;
      axi_wr(IDX_MAP_CTRL, 8'h0D, RESP_OKAY);
      axi_wr(IDX_PORT_DATA, 8'h00, RESP_OKAY);
      repeat (2) @(negedge core_clk);
      `CHK("pix_oe", 3'h7, pin_oe[2:0])
      `CHK("pix", 3'h7, pin_out[2:0])
      axi_wr(IDX_PORT_DIR, 8'h08, RESP_OKAY);
      axi_wr(IDX_PORT_DATA, 8'h08, RESP_OKAY);
      axi_rd(IDX_PORT_DATA, 8'h8F, RESP_OKAY);
      axi_wr(IDX_PORT_DIR, 8'h00, RESP_OKAY);
      axi_wr(IDX_PORT_PULL, 8'h08, RESP_OKAY);
      @(negedge core_clk);
      `CHK("gp_in", 2'h1, {pin_oe[PIN_GPIO], pin_pu[PIN_GPIO]})
      look(16'h8000, 1'b0);
      cs_seen(h);
      `CHK("cs_on", 1'b1, h)
      look(16'h6000, 1'b0);
      cs_seen(h);
      `CHK("cs_off", 1'b0, h)
   endtask : t_emu
   task automatic t_special;
      do_reset(1'b1, 1'b1);
      axi_wr(IDX_MAP_CTRL, 8'h81, RESP_OKAY);
      axi_rd(IDX_PORT_DATA, 8'h00, RESP_SLVERR);
      axi_wr(IDX_PAGE, 8'h02, RESP_OKAY);
      look(16'hC000, 1'b0);
      `CHK("tw", 18'h2C000, {cpu_sel.window, cpu_sel.array, cpu_sel.offset})
      axi_wr(IDX_RAM_BASE, 8'h40, RESP_OKAY);
      axi_wr(IDX_RAM_BASE, 8'h00, RESP_OKAY);
      axi_rd(IDX_RAM_BASE, 8'h00, RESP_OKAY);
      look(16'h0010, 1'b0);
      `CHK("reg", 2'h2, {cpu_sel.regs, cpu_sel.ram})
      look(16'h0800, 1'b0);
      `CHK("ram_ee", 2'h2, {cpu_sel.ram, cpu_sel.eeprom})
      look(16'h3000, 1'b0);
      `CHK("ext", 1'b1, cpu_sel.external)
      axi_rd(IDX_DEC_STAT, 8'h02, RESP_OKAY);
      axi_rd(IDX_PORT_DIR, 8'h00, RESP_SLVERR);
      @(posedge core_clk);
      bdm <= 1'b1;
      look(16'hFF10, 1'b0);
      `CHK("bdm", 2'h2, {cpu_sel.bdm, cpu_sel.window})
      @(posedge core_clk);
      bdm <= 1'b0;
   endtask : t_special
   initial
   begin
      do_reset(1'b0, 1'b0);
      t_reset();
      t_ram();
      t_eeprom();
      t_pages();
      t_emu();
      t_special();
      close_out();
   end
endmodule : memory_relocation_paging_decoder_bench
